// ---- rtl/cms_map.svh ----
// bit positions, reset values and codes of the contact monitor core
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define CMS_FRAME_BITS      32
`define CMS_CMD_LSB         0
`define CMS_CMD_MSB         1
`define CMS_DATA_LSB        2
`define CMS_CH_LSB          3
`define CMS_CH_MSB          26
`define CMS_HI_LSB          27
`define CMS_HI_MSB          31

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define CMS_CMD_WET0        2'h0
`define CMS_CMD_WET1        2'h1
`define CMS_CMD_CFG         2'h2
`define CMS_CMD_NOP         2'h3

// ---------------------------------------------------------------
// status word layout
// ---------------------------------------------------------------
`define CMS_ST_TEMP         24
`define CMS_ST_POR          25
`define CMS_ST_TYPE         26

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CMS_RST_MASK        24'h000000
`define CMS_RST_POL         5'h00
`define CMS_RST_WET         24'h000000
`define CMS_RST_POLL        4'h0
`define CMS_RST_ACT         3'h3
`define CMS_RST_LP          1'h0

`endif

// ---- rtl/cms_pkg.sv ----
// types shared by the contact monitor core
package cms_pkg;

	typedef enum logic [1:0] {
		CMS_CONT,
		CMS_POLL,
		CMS_SHDN
	} cms_mode_t;

endpackage : cms_pkg

// ---- rtl/cms_core.sv ----
// contact monitor core: contact sensing, alert and serial slave port
`timescale 1ns/1ps
`default_nettype none
`include "cms_map.svh"

// Summary of operation
// - power_down_n low forces shutdown; high resumes normal operation.
// - three modes only: continuous, polling, shutdown.
// - each of 24 contact pads reported as a closed_flag in status.
// - per-channel alert_mask_bit decides whether changes may raise the alert.
// - all alert_mask_bits clear after reset.
// - channels 4..22 ground sensing; 0..3 and 23 selectable by polarity_select.
// - polarity_select bits reset to ground sensing.
// - two-bit clean_current_code per channel selects 0, 5, 10 or 15 mA.
// - wetting current driven only into closed contacts.
// - all clean_current_codes zero after reset.
// - alert pulled low on enabled contact change or overtemperature.
// - alert released when chip select falls.
// - polling mode: events during a transaction re-raise alert after select rises.
// - device acts as serial slave for status reads and configuration writes.
// - frame is 32 bits: 30 data bits then 2 command bits.
// - bits counted modulo 32; commit only on nonzero whole multiples.
// - status also carries overtemperature, power-on-reset and device-type flags.
// - serial input sampled on falling link clock while selected.
// - serial output changes on rising link clock; released while deselected.
// - frame written to addressed register on chip select rising edge.
// - command bits pick target register; one code writes nothing.
module cms_core #(
	parameter int          CHANNELS = 24,
	parameter logic [0:0]  DEV_TYPE = 1'h1   // arbitrary type code
) (
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire logic                  CE,
	input  wire logic                  SPI_CLK,
	input  wire logic                  CS_N,
	input  wire logic                  SERIAL_FEED_PIN,
	output var  logic                  SERIAL_OUT_PIN_O,
	output var  logic                  SERIAL_OUT_PIN_OE,
	input  wire logic [CHANNELS-1:0]   CONTACT_PAD,
	input  wire logic                  POWER_DOWN_N,
	input  wire logic                  OVERTEMP,
	output var  logic                  ALERT_N_O,
	output var  logic                  ALERT_N_OE,
	output var  logic [CHANNELS-1:0]   CLOSED_FLAG,
	output var  logic [2*CHANNELS-1:0] CLEAN_CURRENT_CODE,
	output var  logic [CHANNELS-1:0]   ALERT_MASK_BIT,
	output var  logic [4:0]            POLARITY_SELECT,
	output var  logic [3:0]            POLL_TIME_CODE,
	output var  logic [2:0]            POLL_ACTIVE_CODE,
	output var  logic                  LOW_POWER_N,
	output var  cms_pkg::cms_mode_t    MODE
);

	// ---------------------------------------------------------------
	// input synchronisers (system clock)
	// ---------------------------------------------------------------
	logic [CHANNELS-1:0] pad_s1_q;
	logic [CHANNELS-1:0] pad_s2_q;
	logic                cs_s1_q;
	logic                cs_s2_q;
	logic                cs_s3_q;
	logic                pd_s1_q;
	logic                pd_s2_q;
	logic                ot_s1_q;
	logic                ot_s2_q;
	logic                ot_s3_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pad_s1_q <= '0;
			pad_s2_q <= '0;
			cs_s1_q  <= 1'b1;
			cs_s2_q  <= 1'b1;
			cs_s3_q  <= 1'b1;
			pd_s1_q  <= 1'b0;
			pd_s2_q  <= 1'b0;
			ot_s1_q  <= 1'b0;
			ot_s2_q  <= 1'b0;
			ot_s3_q  <= 1'b0;
		end else if (CE) begin
			pad_s1_q <= CONTACT_PAD;
			pad_s2_q <= pad_s1_q;
			cs_s1_q  <= CS_N;
			cs_s2_q  <= cs_s1_q;
			cs_s3_q  <= cs_s2_q;
			pd_s1_q  <= POWER_DOWN_N;
			pd_s2_q  <= pd_s1_q;
			ot_s1_q  <= OVERTEMP;
			ot_s2_q  <= ot_s1_q;
			ot_s3_q  <= ot_s2_q;
		end
	end

	logic cs_rise;
	logic cs_fall;
	logic ot_rise;

	assign cs_rise = cs_s2_q & ~cs_s3_q;
	assign cs_fall = ~cs_s2_q & cs_s3_q;
	assign ot_rise = ot_s2_q & ~ot_s3_q;

	// ---------------------------------------------------------------
	// link side: receive on falling edge, send on rising edge
	// ---------------------------------------------------------------
	logic [`CMS_FRAME_BITS-1:0] stat_q;
	logic [`CMS_FRAME_BITS-1:0] rx_q;
	logic [4:0]                 bit_cnt_q;
	logic                       rx_idle_q;
	logic                       frame_tgl_q;
	logic                       seen_tgl_q;

	// the idle flag is preset by the deselect level itself, so a stopped
	// link clock never has to end the frame
	always_ff @(negedge SPI_CLK or posedge CS_N) begin
		if (CS_N) begin
			rx_idle_q <= 1'b1;
		end else begin
			rx_idle_q <= 1'b0;
		end
	end

	always_ff @(negedge SPI_CLK or posedge RST) begin
		if (RST) begin
			rx_q        <= '0;
			bit_cnt_q   <= 5'h00;
			frame_tgl_q <= 1'b0;
		end else if (!CS_N) begin
			if (rx_idle_q) begin
				frame_tgl_q <= ~frame_tgl_q;
				rx_q      <= {stat_q[`CMS_FRAME_BITS-2:0], SERIAL_FEED_PIN};
				bit_cnt_q <= 5'h01;
			end else begin
				rx_q      <= {rx_q[`CMS_FRAME_BITS-2:0], SERIAL_FEED_PIN};
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
		end
	end

	// after 32 bits the received bits pass straight on for chaining
	always_ff @(posedge SPI_CLK or posedge CS_N) begin
		if (CS_N) begin
			SERIAL_OUT_PIN_O <= 1'b0;
		end else if (rx_idle_q) begin
			SERIAL_OUT_PIN_O <= stat_q[`CMS_FRAME_BITS-1];
		end else begin
			SERIAL_OUT_PIN_O <= rx_q[`CMS_FRAME_BITS-1];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			SERIAL_OUT_PIN_OE <= 1'b0;
		end else if (CE) begin
			SERIAL_OUT_PIN_OE <= ~cs_s2_q;
		end
	end

	// ---------------------------------------------------------------
	// frame commit (link state is quiet while deselected)
	// ---------------------------------------------------------------
	logic                commit;
	logic [1:0]          cmd;
	logic [CHANNELS-1:0] frame_ch;
	logic [4:0]          frame_hi;

	assign commit   = cs_rise & (frame_tgl_q ^ seen_tgl_q) & (bit_cnt_q == 5'h00);
	assign cmd      = rx_q[`CMS_CMD_MSB:`CMS_CMD_LSB];
	assign frame_ch = rx_q[`CMS_CH_MSB:`CMS_CH_LSB];
	assign frame_hi = rx_q[`CMS_HI_MSB:`CMS_HI_LSB];

	logic [CHANNELS-1:0] wet0_q;
	logic [CHANNELS-1:0] wet1_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wet0_q           <= `CMS_RST_WET;
			wet1_q           <= `CMS_RST_WET;
			ALERT_MASK_BIT   <= `CMS_RST_MASK;
			POLARITY_SELECT  <= `CMS_RST_POL;
			POLL_TIME_CODE   <= `CMS_RST_POLL;
			POLL_ACTIVE_CODE <= `CMS_RST_ACT;
			LOW_POWER_N      <= `CMS_RST_LP;
		end else if (CE && commit) begin
			if (cmd == `CMS_CMD_WET0) begin
				wet0_q           <= frame_ch;
				LOW_POWER_N      <= frame_hi[3];
				POLL_ACTIVE_CODE <= frame_hi[2:0];
			end else if (cmd == `CMS_CMD_WET1) begin
				wet1_q         <= frame_ch;
				POLL_TIME_CODE <= frame_hi[3:0];
			end else if (cmd == `CMS_CMD_CFG) begin
				ALERT_MASK_BIT  <= frame_ch;
				POLARITY_SELECT <= frame_hi;
			end
		end
	end

	// ---------------------------------------------------------------
	// operating mode
	// ---------------------------------------------------------------
	cms_pkg::cms_mode_t mode_d;

	always_comb begin
		if (!pd_s2_q) begin
			mode_d = cms_pkg::CMS_SHDN;
		end else if (POLL_TIME_CODE == `CMS_RST_POLL) begin
			mode_d = cms_pkg::CMS_CONT;
		end else begin
			mode_d = cms_pkg::CMS_POLL;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			MODE <= cms_pkg::CMS_SHDN;
		end else if (CE) begin
			case (MODE)
				cms_pkg::CMS_SHDN,
				cms_pkg::CMS_CONT,
				cms_pkg::CMS_POLL: begin
					MODE <= mode_d;
				end
				default: begin
					MODE <= cms_pkg::CMS_SHDN;
				end
			endcase
		end
	end

	logic active;

	assign active = (MODE != cms_pkg::CMS_SHDN);

	// ---------------------------------------------------------------
	// contact sensing and wetting current
	// ---------------------------------------------------------------
	logic [CHANNELS-1:0] batt;
	logic [CHANNELS-1:0] closed_now;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			if (g < 4) begin : g_lo
				assign batt[g] = POLARITY_SELECT[g];
			end else if (g == CHANNELS - 1) begin : g_top
				assign batt[g] = POLARITY_SELECT[4];
			end else begin : g_gnd
				assign batt[g] = 1'b0;
			end
			// ground switch closes to low, battery switch closes to high
			assign closed_now[g] = batt[g] ? pad_s2_q[g] : ~pad_s2_q[g];
		end
	endgenerate

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CLOSED_FLAG <= '0;
		end else if (CE && active) begin
			CLOSED_FLAG <= closed_now;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CLEAN_CURRENT_CODE <= '0;
		end else if (CE) begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (active && CLOSED_FLAG[i]) begin
					CLEAN_CURRENT_CODE[2*i +: 2] <= {wet1_q[i], wet0_q[i]};
				end else begin
					CLEAN_CURRENT_CODE[2*i +: 2] <= 2'h0;
				end
			end
		end
	end

	logic [CHANNELS-1:0] closed_prev_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			closed_prev_q <= '0;
		end else if (CE) begin
			closed_prev_q <= CLOSED_FLAG;
		end
	end

	// ---------------------------------------------------------------
	// alert output
	// ---------------------------------------------------------------
	logic event_now;
	logic pend_q;

	assign event_now = (active && |((CLOSED_FLAG ^ closed_prev_q) & ALERT_MASK_BIT))
		|| ot_rise;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pend_q <= 1'b0;
		end else if (CE) begin
			if (event_now && !cs_s2_q && MODE == cms_pkg::CMS_POLL) begin
				pend_q <= 1'b1;
			end else if (cs_rise) begin
				pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ALERT_N_OE <= 1'b0;
			ALERT_N_O  <= 1'b0;
		end else if (CE) begin
			ALERT_N_O <= 1'b0;
			if (cs_rise && pend_q) begin
				ALERT_N_OE <= 1'b1;
			end else if (event_now && (cs_s2_q || MODE != cms_pkg::CMS_POLL)) begin
				ALERT_N_OE <= 1'b1;
			end else if (cs_fall) begin
				ALERT_N_OE <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// status flags and snapshot
	// ---------------------------------------------------------------
	logic temp_flag_q;
	logic por_flag_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			temp_flag_q <= 1'b0;
		end else if (CE) begin
			if (ot_rise || ot_s2_q) begin
				temp_flag_q <= 1'b1;
			end else if (cs_rise) begin
				temp_flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			por_flag_q <= 1'b0;
			seen_tgl_q <= 1'b0;
		end else if (CE && cs_rise) begin
			por_flag_q <= 1'b1;
			seen_tgl_q <= frame_tgl_q;
		end
	end

	// frozen while selected so the link side sees a steady word
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stat_q <= '0;
		end else if (CE && cs_s2_q) begin
			stat_q                <= '0;
			stat_q[CHANNELS-1:0]  <= CLOSED_FLAG;
			stat_q[`CMS_ST_TEMP]  <= temp_flag_q;
			stat_q[`CMS_ST_POR]   <= por_flag_q;
			stat_q[`CMS_ST_TYPE]  <= DEV_TYPE[0];
		end
	end

endmodule : cms_core

`default_nettype wire

// ---- dv/cms_core_props.sv ----
// concurrent checks on the ports of the contact monitor core
`timescale 1ns/1ps
`default_nettype none
module cms_core_props #(
	parameter int CHANNELS = 24
) (
	input wire logic                  CLK,
	input wire logic                  RST,
	input wire logic                  CS_N,
	input wire logic                  POWER_DOWN_N,
	input wire logic                  SERIAL_OUT_PIN_OE,
	input wire logic                  ALERT_N_OE,
	input wire logic [CHANNELS-1:0]   CLOSED_FLAG,
	input wire logic [2*CHANNELS-1:0] CLEAN_CURRENT_CODE,
	input wire logic [CHANNELS-1:0]   ALERT_MASK_BIT,
	input wire logic [4:0]            POLARITY_SELECT,
	input wire cms_pkg::cms_mode_t    MODE
);
	// ---------------------------------------------------------------
	// helper: any open channel fed with wetting current
	// ---------------------------------------------------------------
	logic wet_open;
	always_comb begin
		wet_open = 1'h0;
		for (int i = 0; i < CHANNELS; i++) begin
			if (!CLOSED_FLAG[i] && CLEAN_CURRENT_CODE[2*i+:2] != 2'h0)
				wet_open = 1'h1;
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	a_cfg_reset: assert property ($fell(RST) |-> ALERT_MASK_BIT == '0
		&& POLARITY_SELECT == 5'h00 && CLEAN_CURRENT_CODE == '0) else $error("config not cleared");
	a_shdn_mode: assert property (!POWER_DOWN_N [*5] |-> MODE == cms_pkg::CMS_SHDN)
		else $error("power-down without shutdown");
	a_mode_legal: assert property (2'(MODE) != 2'h3) else $error("illegal mode");
	a_wet_open: assert property ($stable(CLOSED_FLAG) [*3] |-> !wet_open)
		else $error("wetting current on open contact");
	a_alert_rise: assert property (CS_N && ((CLOSED_FLAG ^ $past(CLOSED_FLAG))
		& ALERT_MASK_BIT) != '0 |-> ##[0:4] ALERT_N_OE) else $error("alert missed");
	a_alert_clear: assert property ($fell(CS_N) |-> ##[1:4] !ALERT_N_OE)
		else $error("alert not released by select");
	a_poll_hold: assert property ((MODE == cms_pkg::CMS_POLL && !CS_N) [*4] |-> !ALERT_N_OE)
		else $error("alert during polling transfer");
	a_cfg_hold: assert property (!CS_N [*2] |=> $stable(ALERT_MASK_BIT)
		&& $stable(POLARITY_SELECT)) else $error("config changed inside transfer");
	a_sdo_release: assert property (CS_N [*4] |-> !SERIAL_OUT_PIN_OE)
		else $error("serial out driven while deselected");
endmodule : cms_core_props

bind cms_core cms_core_props #(.CHANNELS(CHANNELS)) i_props (.CLK(CLK), .RST(RST),
	.CS_N(CS_N), .POWER_DOWN_N(POWER_DOWN_N), .SERIAL_OUT_PIN_OE(SERIAL_OUT_PIN_OE),
	.ALERT_N_OE(ALERT_N_OE), .CLOSED_FLAG(CLOSED_FLAG), .CLEAN_CURRENT_CODE(CLEAN_CURRENT_CODE),
	.ALERT_MASK_BIT(ALERT_MASK_BIT), .POLARITY_SELECT(POLARITY_SELECT), .MODE(MODE));
`default_nettype wire

// ---- dv/cms_spi_master.sv ----
// serial bus master model on the link side of the contact monitor
`timescale 1ns/1ps
`default_nettype none
module cms_spi_master (
	output var  logic SPI_CLK,
	output var  logic CS_N,
	output var  logic SERIAL_FEED_PIN,
	input  wire logic SERIAL_OUT_PIN_O,
	input  wire logic SERIAL_OUT_PIN_OE
);
	logic last = 1'h0;
	initial begin
		SPI_CLK = 1'h0;
		CS_N = 1'h1;
		SERIAL_FEED_PIN = 1'h0;
	end
	// ---------------------------------------------------------------
	// one select period, msb first, 12 ns link clock only inside it
	// ---------------------------------------------------------------
	task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
		rx = '0;
		CS_N = 1'h0;
		#250;
		for (int i = n - 1; i >= 0; i--) begin
			SERIAL_FEED_PIN = tx[i];
			#3 SPI_CLK = 1'h1;
			#6 SPI_CLK = 1'h0;
			// a released line shows the inverse of its last level
			last = SERIAL_OUT_PIN_OE ? SERIAL_OUT_PIN_O : ~last;
			rx = {rx[62:0], last};
			#3;
		end
		// feed line has a pull-down once released
		SERIAL_FEED_PIN = 1'h0;
		#20 CS_N = 1'h1;
		#600;
	endtask : xfer
endmodule : cms_spi_master
`default_nettype wire

// ---- dv/cms_core_tb.sv ----
// self-checking bench for the contact monitor core
`timescale 1ns/1ps
`default_nettype none
`include "cms_map.svh"
module cms_core_tb;
	logic               clk = 1'h0;
	logic               rst = 1'h1;
	logic               pwr_n = 1'h1;
	logic               hot = 1'h0;
	logic [23:0]        pads = 24'hFFFFFF;
	logic [63:0]        rx;
	wire logic          sck, cs_n, serial_feed_pin, so, so_oe, al_oe;
	wire logic [23:0]   closed, mask;
	wire logic [47:0]   wet;
	wire logic [4:0]    pol;
	wire logic [3:0]    pt;
	wire logic [2:0]    pa;
	wire logic          lp, al_o;
	wire cms_pkg::cms_mode_t mode;
	int                 n_fail = 0;
	int                 n_tests = 0;
	int                 cycles = 0;

	always #25 clk = ~clk;

	cms_core i_dut (.CLK(clk), .RST(rst), .CE(1'h1), .SPI_CLK(sck), .CS_N(cs_n),
		.SERIAL_FEED_PIN(serial_feed_pin), .SERIAL_OUT_PIN_O(so), .SERIAL_OUT_PIN_OE(so_oe),
		.CONTACT_PAD(pads), .POWER_DOWN_N(pwr_n), .OVERTEMP(hot), .ALERT_N_O(al_o),
		.ALERT_N_OE(al_oe), .CLOSED_FLAG(closed), .CLEAN_CURRENT_CODE(wet),
		.ALERT_MASK_BIT(mask), .POLARITY_SELECT(pol), .POLL_TIME_CODE(pt),
		.POLL_ACTIVE_CODE(pa), .LOW_POWER_N(lp), .MODE(mode));
	cms_spi_master i_master (.SPI_CLK(sck), .CS_N(cs_n), .SERIAL_FEED_PIN(serial_feed_pin),
		.SERIAL_OUT_PIN_O(so), .SERIAL_OUT_PIN_OE(so_oe));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	task automatic settle;
		repeat (8) @(negedge clk);
	endtask : settle

	function automatic logic [31:0] frm(input logic [1:0] c, input logic [23:0] d,
		input logic [4:0] h);
		return {h, d, 1'h0, c};
	endfunction : frm

	task automatic go(input logic [63:0] tx, input int n);
		i_master.xfer(tx, n, rx);
		settle;
	endtask : go

	task automatic send(input logic [1:0] c, input logic [23:0] d, input logic [4:0] h);
		go({32'h0, frm(c, d, h)}, 32);
	endtask : send

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		chk("mask", '0, 48'(mask));
		chk("pol", '0, 48'(pol));
		chk("wet", '0, wet);
		chk("sdo_oe", '0, 48'(so_oe));
		chk("poll_act", 48'(`CMS_RST_ACT), 48'(pa));
		chk("poll_time", 48'(`CMS_RST_POLL), 48'(pt));
		chk("low_power", '0, 48'(lp));
		chk("alert_o", '0, 48'(al_o));
		chk("mode", 48'(cms_pkg::CMS_CONT), 48'(mode));
		send(`CMS_CMD_NOP, '0, '0);
		chk("stat", 48'h04000000, 48'(rx[31:0]));
		send(`CMS_CMD_NOP, '0, '0);
		chk("stat", 48'h06000000, 48'(rx[31:0]));
	endtask : t_reset

	task automatic t_wet;
		pads = 24'h000000;
		settle;
		send(`CMS_CMD_WET0, 24'h0F0F0F, 5'h0D);
		chk("low_power", 48'h1, 48'(lp));
		chk("poll_act", 48'h5, 48'(pa));
		send(`CMS_CMD_WET1, 24'h00FFFF, 5'h00);
		send(`CMS_CMD_NOP, 24'hFFFFFF, 5'h1F);
		chk("stat", 48'h06FFFFFF, 48'(rx[31:0]));
		chk("closed", 48'hFFFFFF, 48'(closed));
		chk("wet", 48'h0055AAFFAAFF, wet);
		chk("mask", '0, 48'(mask));
		pads = 24'hFFF000;
		settle;
		chk("wet", 48'h000000FFAAFF, wet);
	endtask : t_wet

	task automatic t_frame;
		logic [31:0] f;
		f = frm(`CMS_CMD_CFG, 24'hFFFFFF, 5'h1F);
		go({33'h0, f[31:1]}, 31);
		chk("mask", '0, 48'(mask));
		go('0, 0);
		chk("mask", '0, 48'(mask));
		go({f, frm(`CMS_CMD_CFG, 24'h000100, 5'h00)}, 64);
		chk("mask", 48'h000100, 48'(mask));
		chk("pol", '0, 48'(pol));
		chk("chain", 48'(f), 48'(rx[31:0]));
	endtask : t_frame

	task automatic t_pol;
		send(`CMS_CMD_CFG, 24'h000100, 5'h1F);
		chk("pol", 48'h1F, 48'(pol));
		chk("closed", 48'h800FF0, 48'(closed));
		send(`CMS_CMD_CFG, 24'h000100, 5'h00);
		chk("closed", 48'h000FFF, 48'(closed));
	endtask : t_pol

	task automatic t_alert;
		chk("alert", '0, 48'(al_oe));
		pads[4] = 1'h1;
		settle;
		chk("alert", '0, 48'(al_oe));
		pads[8] = 1'h1;
		settle;
		chk("alert", 48'h1, 48'(al_oe));
		send(`CMS_CMD_NOP, '0, '0);
		chk("alert", '0, 48'(al_oe));
		hot = 1'h1;
		settle;
		chk("alert", 48'h1, 48'(al_oe));
		send(`CMS_CMD_NOP, '0, '0);
		chk("stat", 48'h07000EEF, 48'(rx[31:0]));
		hot = 1'h0;
		send(`CMS_CMD_NOP, '0, '0);
		send(`CMS_CMD_NOP, '0, '0);
		chk("stat", 48'h06000EEF, 48'(rx[31:0]));
	endtask : t_alert

	task automatic t_poll;
		send(`CMS_CMD_WET1, 24'h00FFFF, 5'h01);
		chk("mode", 48'(cms_pkg::CMS_POLL), 48'(mode));
		chk("poll_time", 48'h1, 48'(pt));
		fork
			send(`CMS_CMD_NOP, '0, '0);
			begin
				#300;
				@(negedge clk);
				pads[8] = 1'h0;
			end
		join
		chk("alert", 48'h1, 48'(al_oe));
	endtask : t_poll

	task automatic t_shdn;
		pwr_n = 1'h0;
		settle;
		chk("mode", 48'(cms_pkg::CMS_SHDN), 48'(mode));
		pwr_n = 1'h1;
		settle;
		chk("mode", 48'(cms_pkg::CMS_POLL), 48'(mode));
	endtask : t_shdn

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		repeat (5) @(negedge clk);
		rst = 1'h0;
		settle;
		t_reset();
		t_wet();
		t_frame();
		t_pol();
		t_alert();
		t_poll();
		t_shdn();
		report_and_stop();
	end
endmodule : cms_core_tb
`default_nettype wire
